/* File: design/rxdp_top.sv */
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module rxdp_top
	import rxdp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADC_SDATA,
	input wire logic ADC_FRAME,
	input wire logic SAMPLE_EN,
	input wire logic DAC_EN,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [13:0] DAC_DATA,
	output logic DAC_SLEEP,
	output logic FIRST_AMP_LOW_GAIN,
	output logic SECOND_AMP_LOW_GAIN,
	output logic [SAMPLE_W-1:0] CMOS_DATA,
	output logic CMOS_OE_N,
	output logic [7:0] LVDS_DATA,
	output logic LVDS_ON,
	output logic ADC_RESET,
	output logic [7:0] ADC_CH_PWRDN
);
	logic [CTRL_W-1:0] ctrl_q;
	logic [5:0] gain_q;
	logic adc_rst_q;
	logic [7:0] chpd_q;
	logic aw_q;
	logic w_q;
	logic [7:0] awa_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic [7:0][2:0] sd_sync_q;
	logic [2:0] fr_sync_q;
	logic fr_last_q;
	logic [3:0] bit_q;
	logic [7:0][SAMPLE_W-1:0] shf_q;
	logic [7:0][SAMPLE_W-1:0] word_q;
	logic word_v_q;
	logic fifo_ready;
	logic fifo_valid;
	logic [2*SAMPLE_W-1:0] fifo_data;
	logic pop;
	logic signed [SAMPLE_W-1:0] i_q;
	logic signed [SAMPLE_W-1:0] q_q;
	logic signed [SAMPLE_W-1:0] ic;
	logic signed [SAMPLE_W-1:0] qc;
	logic signed [SAMPLE_W-1:0] dci_q;
	logic signed [SAMPLE_W-1:0] dcq_q;
	logic signed [SAMPLE_W-1:0] gi_q;
	logic signed [SAMPLE_W-1:0] gq_q;
	logic signed [13:0] mix_q;
	logic [1:0] ph_q;
	logic interp_q;
	logic [15:0] lin;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a[7:2] == r[7:2];
	endfunction : hit

	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction : wmask

	// write channel: address and data taken in either order
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_q <= 1'b1;
				awa_q <= S_AXI_AWADDR[7:0];
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_q <= 1'b1;
				wd_q <= S_AXI_WDATA;
				ws_q <= S_AXI_WSTRB;
			end
			if (aw_q && w_q && !S_AXI_BVALID) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (hit(awa_q, ADDR_CTRL) || hit(awa_q, ADDR_GAIN) ||
					hit(awa_q, ADDR_INIT)) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end
	assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_q && !S_AXI_BVALID;

	// control registers, held until rewritten
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= CTRL_RESET;
			gain_q <= GAIN_RESET;
			adc_rst_q <= 1'b0;
			chpd_q <= ~CH_PWR_MASK;
		end else if (aw_q && w_q && !S_AXI_BVALID) begin
			if (hit(awa_q, ADDR_CTRL)) begin
				ctrl_q <= CTRL_W'(wmask(32'(ctrl_q), wd_q, ws_q));
			end
			if (hit(awa_q, ADDR_GAIN) && ws_q[0]) begin
				gain_q <= (wd_q[5:0] > GAIN_MAX) ? GAIN_MAX : wd_q[5:0];
			end
			if (hit(awa_q, ADDR_INIT)) begin
				// host-driven adc init lines; sequence itself is software's job
				adc_rst_q <= wd_q[8];
				chpd_q <= wd_q[7:0];
			end
		end
	end

	// read channel, one-cycle answer
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= RESP_OKAY;
			if (hit(S_AXI_ARADDR[7:0], ADDR_CTRL)) begin
				S_AXI_RDATA <= 32'(ctrl_q);
			end else if (hit(S_AXI_ARADDR[7:0], ADDR_GAIN)) begin
				S_AXI_RDATA <= 32'(gain_q);
			end else if (hit(S_AXI_ARADDR[7:0], ADDR_VERSION)) begin
				S_AXI_RDATA <= FW_VERSION;
			end else if (hit(S_AXI_ARADDR[7:0], ADDR_STATUS)) begin
				S_AXI_RDATA <= {30'h0, fifo_valid, !fifo_ready};
			end else if (hit(S_AXI_ARADDR[7:0], ADDR_INIT)) begin
				S_AXI_RDATA <= {23'h0, adc_rst_q, chpd_q};
			end else begin
				S_AXI_RDATA <= '0;
				S_AXI_RRESP <= RESP_SLVERR;
			end
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	// serial lines come from the adc bit clock domain: three-stage sync
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sd_sync_q <= '0;
			fr_sync_q <= '0;
		end else begin
			for (int c = 0; c < 8; c++) begin
				sd_sync_q[c] <= {sd_sync_q[c][1:0], ADC_SDATA[c]};
			end
			fr_sync_q <= {fr_sync_q[1:0], ADC_FRAME};
		end
	end

	// msb-first deserializer: a frame rise marks the msb of a new word
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bit_q <= '0;
			shf_q <= '0;
			word_q <= '0;
			word_v_q <= 1'b0;
			fr_last_q <= 1'b0;
		end else begin
			word_v_q <= 1'b0;
			if (SAMPLE_EN) begin
				fr_last_q <= fr_sync_q[2];
				for (int c = 0; c < 8; c++) begin
					shf_q[c] <= {shf_q[c][SAMPLE_W-2:0], sd_sync_q[c][2]};
				end
				if (fr_sync_q[2] && fr_sync_q[1] && !fr_last_q) begin
					bit_q <= '0;
					// a partial first word after start is dropped, not passed on
					if (bit_q == SER_LAST) begin
						word_q <= shf_q;
						word_v_q <= 1'b1;
					end
				end else begin
					bit_q <= (bit_q == SER_LAST) ? SER_LAST : bit_q + 1'b1;
				end
			end
		end
	end

	// unprocessed outputs, gated; channels 3,4,7,8 never used
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CMOS_DATA <= '0;
			CMOS_OE_N <= 1'b1;
			LVDS_DATA <= '0;
			LVDS_ON <= 1'b0;
		end else begin
			CMOS_OE_N <= !ctrl_q[CTRL_CMOS_ON];
			LVDS_ON <= ctrl_q[CTRL_LVDS_ON];
			if (word_v_q) begin
				CMOS_DATA <= ctrl_q[CTRL_CMOS_ON] ? word_q[CH_RX_I-1] : '0;
				// offset binary for the lvds path
				LVDS_DATA <= ctrl_q[CTRL_LVDS_ON] ?
					{~word_q[CH_RX_I-1][SAMPLE_W-1], word_q[CH_RX_I-1][SAMPLE_W-2:4]} :
					'0;
			end
		end
	end

	rxdp_fifo #(
		.WIDTH(2*SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.in_valid(word_v_q),
		.in_ready(fifo_ready),
		// source select: receiver on 5/6, sma on 1/2
		.in_data(ctrl_q[CTRL_SRC_SMA] ?
			{word_q[CH_SMA_I-1], word_q[CH_SMA_Q-1]} :
			{word_q[CH_RX_I-1], word_q[CH_RX_Q-1]}),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);
	// processing consumes one pair per two dac ticks, the 61.44 MHz rate
	assign pop = DAC_EN && !interp_q;

	// simple quadrature correction: running dc estimate removed
	assign ic = i_q - dci_q;
	assign qc = q_q - dcq_q;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			i_q <= '0;
			q_q <= '0;
			dci_q <= '0;
			dcq_q <= '0;
		end else if (pop && fifo_valid) begin
			i_q <= fifo_data[2*SAMPLE_W-1:SAMPLE_W];
			q_q <= fifo_data[SAMPLE_W-1:0];
			if (ctrl_q[CTRL_QUAD_CORR]) begin
				dci_q <= dci_q + (ic >>> 6);
				dcq_q <= dcq_q + (qc >>> 6);
			end
		end
	end

	// gain code to linear q8.8 by repeated 0.5 dB steps of 271/256
	always_comb begin
		lin = 16'h00b5;
		for (int k = 0; k < 42; k++) begin
			if (k < int'(gain_q)) begin
				lin = 16'((32'(lin) * 32'd271) >> 8);
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gi_q <= '0;
			gq_q <= '0;
		end else if (SAMPLE_EN && ph_q == 2'h1) begin
			// bypass feeds raw samples into the gain stage
			gi_q <= SAMPLE_W'((32'(signed'(ctrl_q[CTRL_QUAD_CORR] ? ic : i_q)) *
				signed'({16'h0, lin})) >>> 8);
			gq_q <= SAMPLE_W'((32'(signed'(ctrl_q[CTRL_QUAD_CORR] ? qc : q_q)) *
				signed'({16'h0, lin})) >>> 8);
		end
	end

	// interpolate by two and mix to fs/4 on the dac enable
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_q <= '0;
			interp_q <= 1'b0;
			mix_q <= '0;
		end else begin
			if (SAMPLE_EN) begin
				ph_q <= ph_q + 1'b1;
			end
			if (DAC_EN) begin
				interp_q <= !interp_q;
				case ({interp_q, ph_q[1]})
					2'b00: mix_q <= {gi_q, 2'b00};
					2'b01: mix_q <= {gq_q, 2'b00};
					2'b10: mix_q <= -{gi_q, 2'b00};
					default: mix_q <= -{gq_q, 2'b00};
				endcase
			end
		end
	end

	// dac, amplifier and adc init pins; external reference bit drives nothing
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			DAC_DATA <= '0;
			DAC_SLEEP <= 1'b0;
			FIRST_AMP_LOW_GAIN <= 1'b0;
			SECOND_AMP_LOW_GAIN <= 1'b0;
			ADC_RESET <= 1'b0;
			ADC_CH_PWRDN <= '0;
		end else begin
			DAC_DATA <= ctrl_q[CTRL_DAC_DATA] ? mix_q : '0;
			DAC_SLEEP <= !ctrl_q[CTRL_DAC_ON];
			FIRST_AMP_LOW_GAIN <= ctrl_q[CTRL_AMP1_LOW];
			SECOND_AMP_LOW_GAIN <= ctrl_q[CTRL_AMP2_LOW];
			ADC_RESET <= adc_rst_q;
			ADC_CH_PWRDN <= chpd_q;
		end
	end
endmodule : rxdp_top

/* File: design/rxdp_pkg.sv */
package rxdp_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GAIN = 8'h04;
	localparam logic [7:0] ADDR_VERSION = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_INIT = 8'h10;
	// control field positions
	localparam int CTRL_SRC_SMA = 0;
	localparam int CTRL_AMP1_LOW = 1;
	localparam int CTRL_AMP2_LOW = 2;
	localparam int CTRL_DAC_DATA = 3;
	localparam int CTRL_DAC_ON = 4;
	localparam int CTRL_CMOS_ON = 5;
	localparam int CTRL_LVDS_ON = 6;
	localparam int CTRL_QUAD_CORR = 7;
	localparam int CTRL_EXT_REF = 8;
	localparam int CTRL_W = 9;
	// power-up values: receiver path, dac data and dac on, outputs off
	localparam logic [8:0] CTRL_RESET = 9'h018;
	// gain code: step 0.5 dB, code 0 is -3 dB, code 42 is +18 dB
	localparam logic [5:0] GAIN_MAX = 6'h2a;
	localparam logic [5:0] GAIN_RESET = 6'h1d;
	localparam logic [31:0] FW_VERSION = 32'h0000_0005;
	localparam int SAMPLE_W = 12;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] SER_LAST = 4'hb;
	// adc channel numbers (1-based)
	localparam int CH_SMA_I = 1;
	localparam int CH_SMA_Q = 2;
	localparam int CH_RX_I = 5;
	localparam int CH_RX_Q = 6;
	localparam logic [7:0] CH_PWR_MASK = 8'h33;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rxdp_pkg

/* File: design/rxdp_fifo.sv */
`timescale 1ns/1ps
module rxdp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : rxdp_fifo

/* File: test/rxdp_top_chk.sv */
`timescale 1ns/1ps
module rxdp_chk
	import rxdp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic DAC_SLEEP,
	input wire logic FIRST_AMP_LOW_GAIN,
	input wire logic SECOND_AMP_LOW_GAIN,
	input wire logic CMOS_OE_N,
	input wire logic LVDS_ON
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// both halves of the write land on one edge, full strobe assumed
	sequence ctrl_wr;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
			&& S_AXI_AWADDR[7:0] == ADDR_CTRL;
	endsequence
	property follow(pin, int b, bit inv);
		ctrl_wr |-> ##3 pin == ($past(S_AXI_WDATA[b], 3) ^ inv);
	endproperty
	amp1_follow_a: assert property (follow(FIRST_AMP_LOW_GAIN, CTRL_AMP1_LOW, 0))
		else $error("first amp pin wrong");
	amp2_follow_a: assert property (follow(SECOND_AMP_LOW_GAIN, CTRL_AMP2_LOW, 0))
		else $error("second amp pin wrong");
	dac_sleep_a: assert property (follow(DAC_SLEEP, CTRL_DAC_ON, 1))
		else $error("dac sleep pin wrong");
	cmos_gate_a: assert property (follow(CMOS_OE_N, CTRL_CMOS_ON, 1))
		else $error("cmos enable pin wrong");
	lvds_gate_a: assert property (follow(LVDS_ON, CTRL_LVDS_ON, 0))
		else $error("lvds enable pin wrong");
	pins_quiet_a: assert property (!$past(S_AXI_BVALID) |-> $stable({FIRST_AMP_LOW_GAIN,
		SECOND_AMP_LOW_GAIN, DAC_SLEEP, CMOS_OE_N, LVDS_ON})) else $error("pin moved without write");
	write_resp_a: assert property (ctrl_wr |-> ##2 S_AXI_BVALID)
		else $error("write response late");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("address taken during response");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data not held");
endmodule : rxdp_chk
bind rxdp_top rxdp_chk chk_u (.*);

/* File: test/rxdp_adc_model.sv */
`timescale 1ns/1ps
module rxdp_adc_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bit_en,
	input wire logic [7:0] pwrdn,
	input wire logic [11:0] smp_rx,
	input wire logic [11:0] smp_sma,
	output logic [7:0] sdata,
	output logic frame
);
	logic [3:0] bit_q;
	logic [11:0] v;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_q <= 4'h0;
			sdata <= 8'h00;
			frame <= 1'b0;
		end else if (bit_en) begin
			bit_q <= (bit_q == 4'hb) ? 4'h0 : bit_q + 4'h1;
			frame <= bit_q < 4'h6;
			for (int i = 0; i < 8; i++) begin
				// sma on lanes 1,2, receiver on 5,6, rest idle
				v = (i < 2) ? smp_sma : (i == 4 || i == 5) ? smp_rx : 12'h000;
				// powered-down lane toggles, never holds a stale bit
				sdata[i] <= pwrdn[i] ? ~sdata[i] : v[4'hb - bit_q];
			end
		end
	end
endmodule : rxdp_adc_model

/* File: test/rxdp_top_tb.sv */
`timescale 1ns/1ps
module rxdp_top_tb
	import rxdp_pkg::*;
;
	logic SYS_CLK, RST_N, ADC_FRAME, SAMPLE_EN, DAC_EN, S_AXI_AWVALID, S_AXI_WVALID;
	logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, DAC_SLEEP, FIRST_AMP_LOW_GAIN;
	logic SECOND_AMP_LOW_GAIN, CMOS_OE_N, LVDS_ON, ADC_RESET, run_s, run_d;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA, seed, d;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	logic [3:0] S_AXI_WSTRB;
	logic [13:0] DAC_DATA;
	logic [SAMPLE_W-1:0] CMOS_DATA, s_rx, s_sma;
	logic [7:0] ADC_SDATA, LVDS_DATA, ADC_CH_PWRDN;
	int err_total, num_checks, cyc, k;
	rxdp_top dut_u (.*);
	rxdp_adc_model adc_u (.clk(SYS_CLK), .rst_n(RST_N), .bit_en(SAMPLE_EN),
		.pwrdn(ADC_CH_PWRDN), .smp_rx(s_rx), .smp_sma(s_sma), .sdata(ADC_SDATA), .frame(ADC_FRAME));
	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic logic [4:0] pins(input logic [8:0] v);
		return {v[CTRL_AMP1_LOW], v[CTRL_AMP2_LOW], !v[CTRL_DAC_ON], !v[CTRL_CMOS_ON], v[CTRL_LVDS_ON]};
	endfunction : pins
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t %s: got %h want %h", $time, m, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= {24'h0, a};
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= {24'h0, a};
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask : rd
	// bit strobe every cycle, dac strobe every other: sink outruns the source
	always @(posedge SYS_CLK) begin
		SAMPLE_EN <= run_s;
		DAC_EN <= run_d && cyc[0];
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			$display("[ERR] %0t run timed out", $time);
			end_sim();
		end
	end
	initial begin
		{RST_N, run_s, run_d, SAMPLE_EN, DAC_EN, S_AXI_AWVALID, S_AXI_WVALID} = '0;
		{S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = '0;
		S_AXI_WSTRB = 4'hf;
		{err_total, num_checks, cyc} = '0;
		seed = 32'hefad;
		s_rx = 12'h5a3;
		s_sma = 12'h000;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		chk({FIRST_AMP_LOW_GAIN, SECOND_AMP_LOW_GAIN, DAC_SLEEP, CMOS_OE_N, LVDS_ON},
			pins(CTRL_RESET), "reset pins");
		rd(ADDR_CTRL);
		chk(d, CTRL_RESET, "ctrl reset");
		rd(ADDR_GAIN);
		chk(d, GAIN_RESET, "gain reset");
		rd(ADDR_VERSION);
		chk(d, FW_VERSION, "version");
		rd(8'h14);
		chk({d, r}, {32'h0, RESP_SLVERR}, "unmapped read");
		wr(8'h14, 32'h1ff);
		chk(r, RESP_SLVERR, "unmapped write");
		$display("reset and map test done");
		wr(ADDR_INIT, 32'h100);
		repeat (2) @(posedge SYS_CLK);
		chk(ADC_RESET, 1'b1, "adc reset");
		wr(ADDR_INIT, {24'h0, ~CH_PWR_MASK});
		repeat (2) @(posedge SYS_CLK);
		chk({ADC_RESET, ADC_CH_PWRDN}, {1'b0, ~CH_PWR_MASK}, "adc power");
		$display("adc init test done");
		wr(ADDR_CTRL, {23'h0, CTRL_RESET});
		chk(r, RESP_OKAY, "defaults reload");
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			wr(ADDR_CTRL, {23'h0, seed[8:0]});
			rd(ADDR_CTRL);
			chk(d, {23'h0, seed[8:0]}, "ctrl readback");
			chk({FIRST_AMP_LOW_GAIN, SECOND_AMP_LOW_GAIN, DAC_SLEEP, CMOS_OE_N, LVDS_ON},
				pins(seed[8:0]), "ctrl pins");
		end
		wr(ADDR_GAIN, 32'h3f);
		rd(ADDR_GAIN);
		chk(d, GAIN_MAX, "gain clamp");
		$display("control test done");
		wr(ADDR_CTRL, 32'h078);
		run_s <= 1'b1;
		run_d <= 1'b1;
		for (k = 0; k < 3000 && (CMOS_DATA !== s_rx || DAC_DATA === 14'h0); k++) @(posedge SYS_CLK);
		chk(CMOS_DATA, s_rx, "cmos raw ch5");
		chk(LVDS_DATA, s_rx[11:4] ^ 8'h80, "lvds offset binary");
		chk(DAC_DATA !== 14'h0, 1'b1, "receiver path live");
		wr(ADDR_CTRL, 32'h079);
		for (k = 0; k < 3000 && DAC_DATA !== 14'h0; k++) @(posedge SYS_CLK);
		chk(DAC_DATA, 14'h0, "silent sma path");
		wr(ADDR_CTRL, 32'h0f8);
		for (k = 0; k < 3000 && DAC_DATA === 14'h0; k++) @(posedge SYS_CLK);
		chk(DAC_DATA !== 14'h0, 1'b1, "corrected path live");
		wr(ADDR_CTRL, 32'h070);
		for (k = 0; k < 3000 && DAC_DATA !== 14'h0; k++) @(posedge SYS_CLK);
		chk(DAC_DATA, 14'h0, "dac gate closed");
		$display("datapath test done");
		run_d <= 1'b0;
		for (k = 0; k < 300 && d[0] !== 1'b1; k++) rd(ADDR_STATUS);
		chk(d[1:0], 2'b11, "fifo full");
		run_s <= 1'b0;
		run_d <= 1'b1;
		for (k = 0; k < 300 && d[1] !== 1'b0; k++) rd(ADDR_STATUS);
		chk(d[1:0], 2'b00, "fifo empty");
		$display("fifo test done");
		end_sim();
	end
endmodule : rxdp_top_tb
